// ### inc/ssms_pkg.sv
package ssms_pkg;

    // register indices on the plain port (word index, byte addr = 4*index)
    localparam logic [3:0] SSMS_ADDR_EVENT   = 4'h0;
    localparam logic [3:0] SSMS_ADDR_MASK    = 4'h1;
    localparam logic [3:0] SSMS_ADDR_STATE   = 4'h2;
    localparam logic [3:0] SSMS_ADDR_FORCE   = 4'h3;
    localparam logic [3:0] SSMS_ADDR_IRQMSK  = 4'h4;
    localparam int         SSMS_ADDR_W       = 4;

    // field positions shared by event, mask, state and force layouts
    localparam int SSMS_BIT_STSCHG   = 0;
    localparam int SSMS_BIT_DET1     = 1;
    localparam int SSMS_BIT_DET2     = 2;
    localparam int SSMS_BIT_POWER    = 3;
    localparam int SSMS_BIT_LEGACY   = 4;
    localparam int SSMS_BIT_BUSMST   = 5;
    localparam int SSMS_BIT_UNKNOWN  = 7;

    // reset values, and the detect mask code (11) that lets detect events interrupt
    localparam logic [3:0]  SSMS_EVENT_RST  = 4'h0;
    localparam logic [3:0]  SSMS_MASK_RST   = 4'h0;
    localparam logic [1:0]  SSMS_DETMSK_ON  = 2'h3;
    localparam logic [2:0]  SSMS_TYPE_RST   = 3'h0;
    localparam logic [31:0] SSMS_ZERO       = 32'h0000_0000;

    // sense phase: cycles the voltage-sense pins are held low before sampling
    localparam int SSMS_SENSE_CYC   = 4;

    // card type decoded by the sense machine
    typedef enum logic [1:0] {
        SSMS_CARD_LEGACY,
        SSMS_CARD_BUSMST,
        SSMS_CARD_UNKNOWN
    } ssms_card_type;

    // register port request
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ssms_req_type;

    // card pins after the synchronisers
    typedef struct packed {
        logic stschg;
        logic det1_n;
        logic det2_n;
    } ssms_pins_type;

endpackage : ssms_pkg

// ### logic/ssms_socket.sv
`timescale 1ns/1ps
// How it works
// - status-change mask zero: flag only, no interrupt
// - status-change mask cleared on reset, card removal
// - detect mask 00 at reset: flags, no interrupt
// - detect mask 11 lets detect events interrupt
// - power mask zero: power flag, no interrupt
// - mask bits 4-31 reserved, read zero
// - present state read-only, force address writes bit 4 only while card_present is low
// - state bit 0 follows status-change pin live
// - state bits 1,2 mirror detect pins
// - detect sampled while sense pins driven low
// - state bit 3 shows power result
// - bit 4 legacy card, selects legacy mode
// - legacy card disables voltage checking
// - bit 5 bus master card, selects mode
// - bit 7 unknown card type
// - state bit 6 reserved, reads zero
// - interrupt from event flags gated by mask
// - events set flags, write one clears
module ssms_socket
    import ssms_pkg::*;
#(
    parameter int SENSE_CYC = SSMS_SENSE_CYC
) (
    input  wire logic               clk_sys,
    input  wire logic               reset,
    // register port
    input  wire logic [3:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [31:0]        reg_rdata_q,
    // card pins
    input  wire logic               card_status_change,
    input  wire logic               card_detect_one_n,
    input  wire logic               card_detect_two_n,
    input  wire logic               voltage_sense_one_in,
    input  wire logic               voltage_sense_two_in,
    output logic                    voltage_sense_one_out_q,
    output logic                    voltage_sense_one_oe_q,
    output logic                    voltage_sense_two_out_q,
    output logic                    voltage_sense_two_oe_q,
    // power controller
    input  wire logic               power_req,
    input  wire logic               power_done,
    input  wire logic               power_ok,
    // socket configuration
    output logic                    legacy_mode_q,
    output logic                    bus_master_mode_q,
    output logic                    volt_check_en_q,
    // status-changed interrupt
    output logic                    status_irq_q
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    ////////////////////////////////////////////////////////////////////////

    logic [2:0]    sync1_q;            // first stage, read by stage two only
    logic [2:0]    sync2_q;            // second stage
    logic [1:0]    vs_sync1_q;         // sense pin first stage
    logic [1:0]    vs_sync2_q;         // sense pin second stage
    ssms_pins_type pins;               // synchronised pin levels

    // two flops per pin, only stage two reads the first stage
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            // idle levels: status-change low, no card seated
            sync1_q    <= 3'h3;
            sync2_q    <= 3'h3;
            vs_sync1_q <= 2'h0;
            vs_sync2_q <= 2'h0;
        end else begin
            sync1_q    <= {card_status_change, card_detect_one_n,
                           card_detect_two_n};
            sync2_q    <= sync1_q;
            vs_sync1_q <= {voltage_sense_two_in, voltage_sense_one_in};
            vs_sync2_q <= vs_sync1_q;
        end
    end

    assign pins = ssms_pins_type'(sync2_q);

    ////////////////////////////////////////////////////////////////////////
    // register port decode
    ////////////////////////////////////////////////////////////////////////

    ssms_req_type req;                 // bundled request
    wire          wr_event;            // write-one-to-clear event flags
    wire          wr_mask;             // write mask
    wire          wr_force;            // force address write
    wire          wr_irqmsk;           // write extra interrupt mask

    assign req       = '{addr: reg_addr, wdata: reg_wdata,
                         wr: reg_wr, rd: reg_rd};
    assign wr_event  = req.wr && (req.addr == SSMS_ADDR_EVENT);
    assign wr_mask   = req.wr && (req.addr == SSMS_ADDR_MASK);
    assign wr_force  = req.wr && (req.addr == SSMS_ADDR_FORCE);
    assign wr_irqmsk = req.wr && (req.addr == SSMS_ADDR_IRQMSK);

    ////////////////////////////////////////////////////////////////////////
    // detect sensing with sense pins held low
    ////////////////////////////////////////////////////////////////////////

    typedef enum logic [1:0] {
        SSMS_SENSE_DRIVE,
        SSMS_SENSE_SAMPLE,
        SSMS_SENSE_RELEASE
    } ssms_sense_type;

    ssms_sense_type sense_q;           // sense machine state
    ssms_sense_type sense_d;
    logic [7:0]     sense_cnt_q;       // settle counter
    logic           det1_q;            // captured detect one
    logic           det2_q;            // captured detect two
    logic           det_valid_q;       // first capture done
    wire            settle_done;       // pins have settled low

    assign settle_done = (sense_cnt_q == 8'(SENSE_CYC - 1));

    // next state of the sense machine
    always_comb begin
        sense_d = sense_q;
        case (sense_q)
            SSMS_SENSE_DRIVE:   if (settle_done) sense_d = SSMS_SENSE_SAMPLE;
            SSMS_SENSE_SAMPLE:  sense_d = SSMS_SENSE_RELEASE;
            SSMS_SENSE_RELEASE: if (settle_done) sense_d = SSMS_SENSE_DRIVE;
            default:            sense_d = SSMS_SENSE_DRIVE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sense_q     <= SSMS_SENSE_DRIVE;
            sense_cnt_q <= 8'h00;
            det1_q      <= 1'b1;
            det2_q      <= 1'b1;
            det_valid_q <= 1'b0;
        end else begin
            sense_q     <= sense_d;
            sense_cnt_q <= (sense_d != sense_q) ? 8'h00 : sense_cnt_q + 8'h01;
            if (sense_q == SSMS_SENSE_SAMPLE) begin
                det1_q      <= pins.det1_n;
                det2_q      <= pins.det2_n;
                det_valid_q <= 1'b1;
            end
        end
    end

    // sense pins are driven low (oe low = driving) outside release phase
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            voltage_sense_one_out_q <= 1'b0;
            voltage_sense_one_oe_q  <= 1'b0;
            voltage_sense_two_out_q <= 1'b0;
            voltage_sense_two_oe_q  <= 1'b0;
        end else begin
            voltage_sense_one_out_q <= 1'b0;
            voltage_sense_two_out_q <= 1'b0;
            voltage_sense_one_oe_q  <= (sense_d == SSMS_SENSE_RELEASE);
            voltage_sense_two_oe_q  <= (sense_d == SSMS_SENSE_RELEASE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // card type, power state and edges
    ////////////////////////////////////////////////////////////////////////

    logic          stschg_prev_q;      // last status-change level
    logic          det1_prev_q;        // last captured detect one
    logic          det2_prev_q;        // last captured detect two
    logic          power_q;            // power result bit
    logic [2:0]    type_q;             // legacy, bus master, unknown
    wire           ev_stschg;          // status-change pin changed
    wire           ev_det1;            // detect one changed
    wire           ev_det2;            // detect two changed
    wire           card_present;       // both detects low
    wire           removal;            // card leaving
    wire           insertion;          // card arriving
    wire  [1:0]    vs_level;           // sense levels while released
    ssms_card_type card_kind;          // decoded card type
    wire           force_legacy_ok;    // force of bit 4 allowed
    wire           vs_take;            // sense sync shows release levels
    logic          type_pend_q;        // insertion seen, type not decoded

    assign ev_stschg = pins.stschg != stschg_prev_q;
    assign ev_det1   = det_valid_q && (det1_q != det1_prev_q);
    assign ev_det2   = det_valid_q && (det2_q != det2_prev_q);
    assign card_present = !det1_q && !det2_q;
    assign removal   = (ev_det1 || ev_det2) && det1_q && det2_q;
    assign insertion = (ev_det1 || ev_det2) && !(det1_q && det2_q);
    assign vs_level  = vs_sync2_q;
    // sync lag: early in drive the sense sync still holds release levels
    assign vs_take   = (sense_q == SSMS_SENSE_DRIVE) && (sense_cnt_q == 8'h01);

    // simple decode: sense both open = legacy, any grounded = bus master;
    // detect pins disagreeing means the type cannot be told
    assign card_kind = (det1_q != det2_q)   ? SSMS_CARD_UNKNOWN :
                       (vs_level == 2'h3)   ? SSMS_CARD_LEGACY :
                                              SSMS_CARD_BUSMST;
    assign force_legacy_ok = !card_present;

    // edge history
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            stschg_prev_q <= 1'b0;
            det1_prev_q   <= 1'b1;
            det2_prev_q   <= 1'b1;
            type_pend_q   <= 1'b0;
        end else begin
            stschg_prev_q <= pins.stschg;
            det1_prev_q   <= det1_q;
            det2_prev_q   <= det2_q;
            type_pend_q   <= insertion || (type_pend_q && !removal && !vs_take);
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            power_q <= 1'b0;
        end else if (power_done) begin
            power_q <= power_ok;
        end
    end

    // card type kept until another type is inserted; force may write
    // bit 4 only while the detects do not both show a card (card_present low)
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            type_q <= SSMS_TYPE_RST;
        end else if (type_pend_q && vs_take) begin
            type_q <= {card_kind == SSMS_CARD_UNKNOWN,
                       card_kind == SSMS_CARD_BUSMST,
                       card_kind == SSMS_CARD_LEGACY};
        end else if (wr_force && force_legacy_ok) begin
            type_q[0] <= req.wdata[SSMS_BIT_LEGACY];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            legacy_mode_q     <= 1'b0;
            bus_master_mode_q <= 1'b0;
            volt_check_en_q   <= 1'b1;
        end else begin
            legacy_mode_q     <= type_q[0];
            bus_master_mode_q <= type_q[1];
            volt_check_en_q   <= !type_q[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event flags, mask and interrupt
    ////////////////////////////////////////////////////////////////////////

    logic [3:0] event_q;               // sticky event flags
    logic [3:0] mask_q;                // status-change mask bits 3..0
    logic [3:0] irqmsk_q;              // extra enable, same layout
    wire  [3:0] ev_set;                // hardware and force sets
    wire  [3:0] ev_clr;                // software clears
    wire  [3:0] gate;                  // per-flag interrupt permit

    assign ev_set = {power_done,
                     ev_det2, ev_det1, ev_stschg}
                  | (wr_force ? req.wdata[3:0] : 4'h0);
    assign ev_clr = wr_event ? req.wdata[3:0] : 4'h0;

    // sticky flags, a set in the clearing cycle wins
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            event_q <= SSMS_EVENT_RST;
        end else begin
            event_q <= (event_q & ~ev_clr) | ev_set;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mask_q <= SSMS_MASK_RST;
        end else begin
            if (wr_mask) begin
                mask_q <= req.wdata[3:0];
            end
            if (removal) begin
                mask_q[SSMS_BIT_STSCHG] <= 1'b0;
            end
        end
    end

    // extra enable register, all on after reset
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irqmsk_q <= 4'hf;
        end else if (wr_irqmsk) begin
            irqmsk_q <= req.wdata[3:0];
        end
    end

    assign gate[SSMS_BIT_STSCHG] = mask_q[SSMS_BIT_STSCHG];
    assign gate[SSMS_BIT_POWER]  = mask_q[SSMS_BIT_POWER];
    assign gate[SSMS_BIT_DET1]   = mask_q[2:1] == SSMS_DETMSK_ON;
    assign gate[SSMS_BIT_DET2]   = mask_q[2:1] == SSMS_DETMSK_ON;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            status_irq_q <= 1'b0;
        end else begin
            status_irq_q <= |(event_q & gate & irqmsk_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data
    ////////////////////////////////////////////////////////////////////////

    wire [31:0] state_word;            // present state view
    wire [31:0] rd_mux;                // selected word

    assign state_word = {24'h00_0000, type_q[2], 1'b0, type_q[1], type_q[0],
                         power_q, det2_q, det1_q, pins.stschg};
    assign rd_mux = (req.addr == SSMS_ADDR_EVENT)  ? {28'h000_0000, event_q} :
                    (req.addr == SSMS_ADDR_MASK)   ? {28'h000_0000, mask_q} :
                    (req.addr == SSMS_ADDR_STATE)  ? state_word :
                    (req.addr == SSMS_ADDR_IRQMSK) ? {28'h000_0000, irqmsk_q} :
                                                     SSMS_ZERO;

    // data stands only in the cycle after the read strobe
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            reg_rdata_q <= SSMS_ZERO;
        end else begin
            reg_rdata_q <= req.rd ? rd_mux : SSMS_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    ////////////////////////////////////////////////////////////////////////

    stschg_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
        (!mask_q[0] && event_q == 4'h1) |=> !status_irq_q)
        else $error("status-change flag raised irq while masked");

    mask_remove_a: assert property (@(posedge clk_sys) disable iff (reset)
        removal |=> !mask_q[0])
        else $error("status-change mask kept after removal");

    detect_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
        (mask_q[2:1] != 2'h3 && event_q[2:1] != 2'h0 && event_q[0] == 1'b0
         && event_q[3] == 1'b0) |=> !status_irq_q)
        else $error("detect flag raised irq while masked");

    detect_open_a: assert property (@(posedge clk_sys) disable iff (reset)
        (mask_q[2:1] == 2'h3 && event_q[1] && irqmsk_q[1]) |=> status_irq_q)
        else $error("unmasked detect flag gave no irq");

    power_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
        power_done |=> event_q[3] && power_q == $past(power_ok))
        else $error("power completion not recorded");

    state_ro_a: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_wr && reg_addr == SSMS_ADDR_STATE) |=> $stable(type_q))
        else $error("state register changed by its own address");

    reserved_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
        $past(reg_rd) |-> reg_rdata_q[31:8] == 24'h0 && !reg_rdata_q[6])
        else $error("reserved read bits not zero");

    legacy_check_a: assert property (@(posedge clk_sys) disable iff (reset)
        type_q[0] |=> !volt_check_en_q && legacy_mode_q)
        else $error("legacy card left voltage checking on");

    flag_sticky_a: assert property (@(posedge clk_sys) disable iff (reset)
        (event_q[0] && !(wr_event && reg_wdata[0])) |=> event_q[0])
        else $error("event flag dropped without a clear");

endmodule : ssms_socket

// ### tb/ssms_card_model.sv
`timescale 1ns/1ps
// card side of the socket: detect, sense and status-change pins
module ssms_card_model (
    input  wire logic present,                 // card fully seated
    input  wire logic half,                    // only one detect contact
    input  wire logic sense_high,              // card leaves sense high
    input  wire logic short_one,               // detect one tied to sense
    input  wire logic stschg,                  // card status request
    input  wire logic voltage_sense_one_out_q, // adapter drive level
    input  wire logic voltage_sense_one_oe_q,  // low = adapter drives
    input  wire logic voltage_sense_two_out_q, // adapter drive level
    input  wire logic voltage_sense_two_oe_q,  // low = adapter drives
    output logic      card_status_change,      // status-change pin
    output logic      card_detect_one_n,       // low = card
    output logic      card_detect_two_n,       // low = card
    output logic      voltage_sense_one_in,    // resolved sense line
    output logic      voltage_sense_two_in     // resolved sense line
);
    logic seated; // any contact made
    logic lvl;    // level on a released sense line
    assign seated = present | half;
    // empty socket: pull-up wins on a released line
    assign lvl = ~seated | sense_high;
    // wire level from the adapter's enable
    assign voltage_sense_one_in = voltage_sense_one_oe_q ? lvl
                                : voltage_sense_one_out_q;
    assign voltage_sense_two_in = voltage_sense_two_oe_q ? lvl
                                : voltage_sense_two_out_q;
    // shorted detect follows the sense line, so reads lvl while sense released
    assign card_detect_one_n = ~seated ? 1'b1
                             : (short_one ? voltage_sense_one_in : 1'b0);
    assign card_detect_two_n = ~present;
    // card raises status change by level
    assign card_status_change = stschg;
endmodule : ssms_card_model

// ### tb/ssms_socket_bench.sv
`timescale 1ns/1ps
module ssms_socket_bench;
    import ssms_pkg::*;
    logic        clk_sys = 1'b0;  // 50 MHz
    logic        reset   = 1'b1;  // async, active high
    logic [3:0]  reg_addr  = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0, reg_rd = 1'b0;
    logic [31:0] reg_rdata_q;
    logic        power_req = 1'b0, power_done = 1'b0, power_ok = 1'b0;
    logic        present = 1'b0, half = 1'b0, sense_high = 1'b0;
    logic        short_one = 1'b0, stschg = 1'b0;
    logic        stc, det1_n, det2_n, vs1_in, vs2_in;
    logic        vs1_out, vs1_oe, vs2_out, vs2_oe;
    logic        legacy_mode_q, bus_master_mode_q, volt_check_en_q;
    logic        status_irq_q;
    int          error_cnt = 0; // mismatches
    int          checks    = 0; // comparisons
    always #10 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////
    // short sense count keeps each capture quick
    ssms_socket #(.SENSE_CYC(2)) u_ssms_socket (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .card_status_change(stc),
        .card_detect_one_n(det1_n), .card_detect_two_n(det2_n),
        .voltage_sense_one_in(vs1_in), .voltage_sense_two_in(vs2_in),
        .voltage_sense_one_out_q(vs1_out), .voltage_sense_one_oe_q(vs1_oe),
        .voltage_sense_two_out_q(vs2_out), .voltage_sense_two_oe_q(vs2_oe),
        .power_req(power_req), .power_done(power_done),
        .power_ok(power_ok), .legacy_mode_q(legacy_mode_q),
        .bus_master_mode_q(bus_master_mode_q),
        .volt_check_en_q(volt_check_en_q), .status_irq_q(status_irq_q));
    ssms_card_model u_ssms_card_model (
        .present(present), .half(half), .sense_high(sense_high),
        .short_one(short_one), .stschg(stschg),
        .voltage_sense_one_out_q(vs1_out), .voltage_sense_one_oe_q(vs1_oe),
        .voltage_sense_two_out_q(vs2_out), .voltage_sense_two_oe_q(vs2_oe),
        .card_status_change(stc), .card_detect_one_n(det1_n),
        .card_detect_two_n(det2_n), .voltage_sense_one_in(vs1_in),
        .voltage_sense_two_in(vs2_in));
    ////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] e,
                      input string nm);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(nm, e, reg_rdata_q);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : idle
    // flag settles a cycle after its cause
    task automatic pin(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask : pin
    task automatic irq(input logic e);
        idle(4);
        pin("irq", e, status_irq_q);
    endtask : irq
    task automatic clr;
        wr(SSMS_ADDR_EVENT, 32'h0000_000F);
    endtask : clr
    // power controller finish pulse
    task automatic pwr(input logic ok);
        @(posedge clk_sys);
        power_req  <= 1'b1;
        power_done <= 1'b1;
        power_ok   <= ok;
        @(posedge clk_sys);
        power_req  <= 1'b0;
        power_done <= 1'b0;
    endtask : pwr
    task automatic test_done;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////
    // watchdog: whole sequence needs well under 2000 cycles
    initial begin
        #(20 * 20000);
        error_cnt++;
        test_done;
    end
    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        idle(20);
        rd(SSMS_ADDR_MASK, 32'h0000_0000, "mask rst");
        rd(SSMS_ADDR_EVENT, 32'h0000_0000, "event rst");
        rd(SSMS_ADDR_STATE, 32'h0000_0006, "state rst");
        pin("vchk rst", 1'b1, volt_check_en_q);
        // reserved mask bits and read-only state
        wr(SSMS_ADDR_MASK, 32'hFFFF_FFFF);
        rd(SSMS_ADDR_MASK, 32'h0000_000F, "mask rsv");
        wr(SSMS_ADDR_STATE, 32'h0000_00FF);
        rd(SSMS_ADDR_STATE, 32'h0000_0006, "state ro");
        rd(4'h5, 32'h0000_0000, "unmapped");
        wr(SSMS_ADDR_MASK, 32'h0000_0000);
        // status-change flag with mask bit 0 closed, then open
        wr(SSMS_ADDR_FORCE, 32'h0000_0001);
        irq(1'b0);
        rd(SSMS_ADDR_EVENT, 32'h0000_0001, "event sc");
        wr(SSMS_ADDR_MASK, 32'h0000_0001);
        irq(1'b1);
        clr;
        irq(1'b0);
        // every detect mask code; only 11 lets it through
        for (int c = 0; c < 4; c++) begin
            wr(SSMS_ADDR_MASK, {29'h0, c[1:0], 1'b0});
            wr(SSMS_ADDR_FORCE, 32'h0000_0006);
            irq(c == 3);
            clr;
        end
        // power result and its flag
        wr(SSMS_ADDR_MASK, 32'h0000_0000);
        pwr(1'b1);
        irq(1'b0);
        rd(SSMS_ADDR_EVENT, 32'h0000_0008, "event pw");
        rd(SSMS_ADDR_STATE, 32'h0000_000E, "power up");
        wr(SSMS_ADDR_MASK, 32'h0000_0008);
        irq(1'b1);
        clr;
        pwr(1'b0);
        rd(SSMS_ADDR_STATE, 32'h0000_0006, "power dn");
        clr;
        wr(SSMS_ADDR_MASK, 32'h0000_0000);
        // live status-change pin
        stschg <= 1'b1;
        idle(6);
        rd(SSMS_ADDR_STATE, 32'h0000_0007, "sc high");
        stschg <= 1'b0;
        idle(6);
        rd(SSMS_ADDR_STATE, 32'h0000_0006, "sc low");
        rd(SSMS_ADDR_EVENT, 32'h0000_0001, "sc edges");
        clr;
        // legacy card, detect one shorted to a sense line
        wr(SSMS_ADDR_MASK, 32'h0000_0001);
        sense_high <= 1'b1;
        short_one  <= 1'b1;
        present    <= 1'b1;
        idle(40);
        rd(SSMS_ADDR_STATE, 32'h0000_0010, "legacy");
        rd(SSMS_ADDR_EVENT, 32'h0000_0006, "insert");
        pin("legacy mode", 1'b1, legacy_mode_q);
        pin("vchk off", 1'b0, volt_check_en_q);
        present <= 1'b0;
        idle(40);
        rd(SSMS_ADDR_MASK, 32'h0000_0000, "removal");
        clr;
        // bus-master card
        sense_high <= 1'b0;
        short_one  <= 1'b0;
        present    <= 1'b1;
        idle(40);
        rd(SSMS_ADDR_STATE, 32'h0000_0020, "busmst");
        pin("bm mode", 1'b1, bus_master_mode_q);
        pin("bm legacy", 1'b0, legacy_mode_q);
        present <= 1'b0;
        idle(40);
        // card seated on one detect only
        half <= 1'b1;
        idle(40);
        rd(SSMS_ADDR_STATE, 32'h0000_0084, "unknown");
        half <= 1'b0;
        idle(40);
        clr;
        test_done;
    end
endmodule : ssms_socket_bench
